// ==== rtl/sttp_pkg.sv ====
package sttp_pkg;

    // =========================================================
    // Self-test sequencing
    // =========================================================
    // Cycles each internal self-test step lasts (plain default).
    localparam int unsigned STEP_CYCLES  = 16;
    localparam int unsigned STEP_W       = 5;
    // Number of internal self-test steps.
    localparam int unsigned NUM_TESTS    = 4;
    localparam int unsigned TEST_W       = 3;
    // Cycles of the external bus confidence test (plain default).
    localparam int unsigned BUS_CYCLES   = 8;
    // Cycles counted in local reset after the strap is latched; the local bus reset output rises one cycle later.
    localparam int unsigned LRST_CYCLES  = 4;
    localparam logic        FAIL_LEVEL   = 1'b0;
    localparam logic        PASS_LEVEL   = 1'b1;

    typedef enum logic [2:0] {
        STTP_LRST,
        STTP_SELF,
        STTP_BUS,
        STTP_RUN,
        STTP_HALT
    } sttp_init_t;

    // =========================================================
    // Test access port
    // =========================================================
    localparam int unsigned IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } sttp_tap_t;

    // Status that the core side offers the link.
    typedef struct packed {
        logic fail_n;
        logic halted;
        logic bridge_on;
    } sttp_status_t;

endpackage

// ==== rtl/sttp_top.sv ====
`timescale 1ns/1ps
module sttp_top
    import sttp_pkg::*;
(
    // System clock and primary reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Board straps and self-test result from the test engine
    input  wire logic selftest_enable_in,
    input  wire logic test_error,
    input  wire logic bus_error,
    // Status pins
    output logic      fail_n,
    output logic      local_rst_n,
    output logic      core_run,
    output logic      bridge_enable,
    // Boundary-scan port
    input  wire logic tck,
    input  wire logic trst_n,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tdo,
    output logic      tdo_oe
);

    // =========================================================
    // Input synchronisers
    // =========================================================
    logic strap_m, strap_s, err_m, err_s, berr_m, berr_s;

    // Pins come from off chip; each passes two flops first.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err_m   <= 1'b0;
            err_s   <= 1'b0;
            berr_m  <= 1'b0;
            berr_s  <= 1'b0;
        end else begin
            err_m   <= test_error;
            err_s   <= err_m;
            berr_m  <= bus_error;
            berr_s  <= berr_m;
        end
    end

    // The strap pair keeps running through reset, so it already holds the settled pin
    // when reset ends; clearing it there would hand a zero to the one-shot latch.
    always_ff @(posedge sys_clk) begin
        strap_m <= selftest_enable_in;
        strap_s <= strap_m;
    end

    // =========================================================
    // Initialisation sequencer
    // =========================================================
    sttp_init_t            state;
    logic [STEP_W-1:0]     cnt;
    logic [TEST_W-1:0]     test_idx;
    logic                  strap_taken;
    logic                  strap_val;

    // The strap is latched in the first clocked cycle after release, never by the reset.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_taken <= 1'b0;
            strap_val   <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            strap_val   <= strap_s;
        end
    end

    // Sequence: local reset, optional self-test, bus test, then run or halt.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state    <= STTP_LRST;
            cnt      <= '0;
            test_idx <= '0;
        end else begin
            case (state)
                STTP_LRST: begin
                    if (strap_taken && cnt >= STEP_W'(LRST_CYCLES - 1)) begin
                        cnt   <= '0;
                        state <= strap_val ? STTP_SELF : STTP_BUS;
                    end else if (strap_taken) begin
                        cnt <= cnt + 1'b1;
                    end
                end
                STTP_SELF: begin
                    if (err_s) begin
                        state <= STTP_HALT;
                    end else if (cnt == STEP_W'(STEP_CYCLES - 1)) begin
                        cnt <= '0;
                        if (test_idx == TEST_W'(NUM_TESTS - 1)) begin
                            state <= STTP_BUS;
                        end else begin
                            test_idx <= test_idx + 1'b1;
                        end
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                STTP_BUS: begin
                    if (berr_s) begin
                        state <= STTP_HALT;
                    end else if (cnt == STEP_W'(BUS_CYCLES - 1)) begin
                        state <= STTP_RUN;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                STTP_RUN:  state <= STTP_RUN;
                STTP_HALT: state <= STTP_HALT;
                default:   state <= STTP_HALT;
            endcase
        end
    end

    // Outputs come straight from flops so the pins never glitch.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fail_n        <= FAIL_LEVEL;
            local_rst_n   <= 1'b0;
            core_run      <= 1'b0;
            bridge_enable <= 1'b0;
        end else begin
            local_rst_n   <= (state != STTP_LRST);
            core_run      <= (state == STTP_RUN);
            bridge_enable <= (state != STTP_LRST);
            case (state)
                STTP_SELF: begin
                    if (cnt == STEP_W'(STEP_CYCLES - 1) && !err_s) begin
                        fail_n <= ~fail_n;
                    end
                end
                STTP_BUS:  fail_n <= FAIL_LEVEL;
                STTP_RUN:  fail_n <= PASS_LEVEL;
                STTP_HALT: fail_n <= FAIL_LEVEL;
                default:   fail_n <= FAIL_LEVEL;
            endcase
        end
    end

    // =========================================================
    // Test access port (tck domain)
    // =========================================================
    sttp_tap_t         tap, next_tap;
    logic [IR_W-1:0]   ir_shift, ir;
    logic              byp;

    // Standard transitions decided by the test mode select.
    always_comb begin
        next_tap = TAP_RESET;
        case (tap)
            TAP_RESET:    next_tap = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:     next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   next_tap = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR:   next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
            default:      next_tap = TAP_RESET;
        endcase
    end

    // The controller resets on trst_n without waiting for a test clock edge.
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tap <= TAP_RESET;
        end else begin
            tap <= next_tap;
        end
    end

    // Instruction and bypass registers capture on the rising edge.
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_shift <= IR_BYPASS;
            ir       <= IR_BYPASS;
            byp      <= 1'b0;
        end else begin
            case (tap)
                TAP_RESET:    ir <= IR_BYPASS;
                TAP_CAP_IR:   ir_shift <= IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift <= {tdi, ir_shift[IR_W-1:1]};
                TAP_UPD_IR:   ir <= ir_shift;
                TAP_CAP_DR:   byp <= 1'b0;
                TAP_SHIFT_DR: byp <= tdi;
                default:      byp <= byp;
            endcase
        end
    end

    // Output launches on the falling edge; the driver is off outside shift states.
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= (tap == TAP_SHIFT_IR) ? ir_shift[0] : byp;
            tdo_oe <= (tap == TAP_SHIFT_IR) || (tap == TAP_SHIFT_DR);
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    fail_low_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(strap_taken) |-> fail_n == FAIL_LEVEL)
        else $error("fail output not low after reset");
    pass_run_a: assert property (@(posedge sys_clk) disable iff (rst)
        core_run |-> fail_n == PASS_LEVEL)
        else $error("core running without pass level");
    halt_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == STTP_HALT |=> ##1 (fail_n == FAIL_LEVEL && !core_run))
        else $error("halted core shows pass or runs");
    bridge_up_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == STTP_HALT |=> bridge_enable)
        else $error("bridge stopped by self-test failure");
    skip_self_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == STTP_LRST && !strap_val) |=> state != STTP_SELF)
        else $error("self-test ran while disabled");
    strap_once_a: assert property (@(posedge sys_clk) disable iff (rst)
        strap_taken |=> $stable(strap_val))
        else $error("strap resampled");
    lrst_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == STTP_SELF |=> local_rst_n)
        else $error("local reset still low");
    tdo_float_a: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_oe == (tap == TAP_SHIFT_IR || tap == TAP_SHIFT_DR))
        else $error("tdo driven outside shift");
    tap_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
        (tms [*5]) |=> tap == TAP_RESET)
        else $error("five tms highs did not reach reset");
    shift_in_a: assert property (@(posedge tck) disable iff (!trst_n)
        tap == TAP_SHIFT_DR |=> byp == $past(tdi))
        else $error("bypass did not take tdi");
    // Each finished step flips the status pin so a board monitor can count steps.
    step_toggle_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == STTP_SELF && !err_s && cnt == STEP_W'(STEP_CYCLES - 1))
            |=> fail_n != $past(fail_n))
        else $error("fail output did not toggle at step end");
    // A clean bus test hands over to user code on the next edge.
    run_after_bus_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == STTP_BUS && !berr_s && cnt == STEP_W'(BUS_CYCLES - 1))
            |=> state == STTP_RUN)
        else $error("clean bus test did not start user code");
    // A test error during self-test or a bus error during the bus test halts the core for good.
    err_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((state == STTP_SELF && err_s) || (state == STTP_BUS && berr_s))
            |=> state == STTP_HALT)
        else $error("error did not halt the core");
    // The local bus stays in reset as long as the sequencer waits.
    lrst_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == STTP_LRST |=> !local_rst_n)
        else $error("local reset released too early");
    // A strap sampled high starts the internal self-test after local reset.
    self_after_lrst_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == STTP_LRST && strap_taken && strap_val && cnt >= STEP_W'(LRST_CYCLES - 1))
            |=> state == STTP_SELF)
        else $error("self-test skipped while enabled");
    // The test reset holds the controller and the driver off with no test clock at all.
    trst_hold_a: assert property (@(posedge sys_clk)
        !trst_n |-> (tap == TAP_RESET && !tdo_oe))
        else $error("test reset did not hold the controller");
    // The launched bit is the low end of whichever register is shifting.
    tdo_launch_a: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_oe |-> tdo == ((tap == TAP_SHIFT_IR) ? ir_shift[0] : byp))
        else $error("tdo does not match the shifting register");
    // The controller reset selects bypass; an update loads the shifted instruction.
    ir_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
        tap == TAP_RESET |=> ir == IR_BYPASS)
        else $error("reset did not select bypass");
    ir_update_a: assert property (@(posedge tck) disable iff (!trst_n)
        tap == TAP_UPD_IR |=> ir == $past(ir_shift))
        else $error("update did not load the instruction");
    // A high mode bit leaves idle for the data column.
    tms_idle_a: assert property (@(posedge tck) disable iff (!trst_n)
        (tap == TAP_IDLE && tms) |=> tap == TAP_SEL_DR)
        else $error("idle did not follow the mode bit");

endmodule

// ==== verification/selftest_status_and_test_port_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    if ((got) !== (exp)) begin \
        $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
        n_fail++; \
    end \
    n_tests++; \
end
// =========================================================
// Bench top
// =========================================================
module selftest_status_and_test_port_tb;
    import sttp_pkg::*;
    logic sys_clk, rst, strap, terr, berr, fail_n, local_rst_n, core_run, bridge_enable;
    logic tck, trst_n, tms, tdi, tdo, tdo_oe;
    int   n_fail = 0;
    int   n_tests = 0;

    sttp_top uut (.sys_clk(sys_clk), .rst(rst), .selftest_enable_in(strap),
        .test_error(terr), .bus_error(berr), .fail_n(fail_n), .local_rst_n(local_rst_n),
        .core_run(core_run), .bridge_enable(bridge_enable), .tck(tck), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    sttp_jtag_model jt (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // System clock at 125 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Inputs change 1 ns after the edge so the design never races them.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // The strap settles with reset asserted, well ahead of the release.
    task automatic do_reset(input logic st, input logic te, input logic be);
        rst = 1'b1;
        strap = st;
        terr = te;
        berr = be;
        #1;
        `CHK("fail_n at reset", FAIL_LEVEL, fail_n)
        tick(8);
        `CHK("local_rst_n in reset", 1'b0, local_rst_n)
        rst = 1'b0;
    endtask

    // Counts fail_n changes until user code starts, bounded in cycles.
    task automatic wait_run(output int tog, output int cyc);
        logic last;
        tog = 0;
        cyc = 0;
        last = fail_n;
        while (core_run !== 1'b1 && cyc < 300) begin
            tick(1);
            cyc++;
            if (fail_n !== last) tog++;
            last = fail_n;
        end
    endtask

    task automatic test_full;
        int tog, cyc;
        do_reset(1'b1, 1'b0, 1'b0);
        wait_run(tog, cyc);
        `CHK("core_run", 1'b1, core_run)
        `CHK("fail_n passed", PASS_LEVEL, fail_n)
        `CHK("self-test length", 1'b1, cyc >= NUM_TESTS * STEP_CYCLES)
        `CHK("step toggles", NUM_TESTS + 1, tog)
        `CHK("local_rst_n", 1'b1, local_rst_n)
        $display("test_full done");
    endtask

    // A late strap change must not bring the internal self-test back.
    task automatic test_skip;
        int tog, cyc;
        do_reset(1'b0, 1'b0, 1'b0);
        tick(3);
        strap = 1'b1;
        wait_run(tog, cyc);
        `CHK("core_run", 1'b1, core_run)
        `CHK("single rise", 1, tog)
        `CHK("strap ignored", 1'b1, cyc < NUM_TESTS * STEP_CYCLES)
        `CHK("bus test length", 1'b1, cyc >= BUS_CYCLES)
        $display("test_skip done");
    endtask

    task automatic test_self_err;
        do_reset(1'b1, 1'b0, 1'b0);
        tick(20);
        terr = 1'b1;
        tick(10);
        terr = 1'b0;
        tick(100);
        `CHK("fail_n held", FAIL_LEVEL, fail_n)
        `CHK("core halted", 1'b0, core_run)
        `CHK("bridge alive", 1'b1, bridge_enable)
        $display("test_self_err done");
    endtask

    task automatic test_bus_err;
        do_reset(1'b0, 1'b0, 1'b1);
        tick(40);
        `CHK("fail_n held", FAIL_LEVEL, fail_n)
        `CHK("core halted", 1'b0, core_run)
        `CHK("bridge alive", 1'b1, bridge_enable)
        berr = 1'b0;
        $display("test_bus_err done");
    endtask

    // From reset: idle, into shift-IR, four bits out, update, idle.
    task automatic test_tap_scan;
        jt.frame(32'h306, 32'h1E0, 11);
        `CHK("ir capture out", IR_CAPTURE, jt.cap_tdo[8:5])
        `CHK("tdo drive window", 7'h1E, jt.cap_oe[10:4])
        $display("test_tap_scan done");
    endtask

    // From idle: bypass capture, three bits, pause and resume, one bit, update, idle.
    task automatic test_dr_scan;
        jt.frame(32'h6A1, 32'h028, 12);
        `CHK("bypass out", 3'h2, jt.cap_tdo[5:3])
        `CHK("bypass after pause", 1'b1, jt.cap_tdo[9])
        `CHK("dr drive window", 9'h08E, jt.cap_oe[10:2])
        $display("test_dr_scan done");
    endtask

    task automatic test_trst;
        jt.frame(32'h006, 32'h0, 6);
        #2;
        `CHK("shift-ir drive", 1'b1, tdo_oe)
        jt.set_trst(1'b0);
        #2;
        `CHK("tdo_oe after trst", 1'b0, tdo_oe)
        jt.set_trst(1'b1);
        $display("test_trst done");
    endtask

    // Five high mode bits reach reset from shift-IR.
    task automatic test_tms_reset;
        jt.frame(32'h006, 32'h0, 6);
        jt.frame(32'h1F, 32'h0, 5);
        test_tap_scan;
        $display("test_tms_reset done");
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        rst = 1'b0;
        strap = 1'b0;
        terr = 1'b0;
        berr = 1'b0;
        #1;
        test_full;
        test_skip;
        test_self_err;
        test_bus_err;
        jt.set_trst(1'b1);
        test_tap_scan;
        test_dr_scan;
        test_trst;
        test_tms_reset;
        end_of_test;
    end

    // The tests need a few hundred cycles; this cuts off a hang.
    initial begin
        #200000;
        n_fail++;
        end_of_test;
    end
endmodule

// ==== verification/sttp_jtag_model.sv ====
`timescale 1ns/1ps
// =========================================================
// Boundary-scan tester
// =========================================================
module sttp_jtag_model (
    // Pins driven towards the device
    output logic      tck,
    output logic      trst_n,
    output logic      tms,
    output logic      tdi,
    // Pins coming back
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic [31:0] cap_tdo;
    logic [31:0] cap_oe;

    // Pulled-up pins rest high and the clock rests low outside frames.
    // The test reset falls after time zero so the controller sees a real edge.
    initial begin
        tck = 1'b0;
        trst_n = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        #1;
        trst_n = 1'b0;
    end

    // One framed burst; the device output is sampled as each rising edge comes.
    task automatic frame(input logic [31:0] ms, input logic [31:0] di, input int n);
        for (int i = 0; i < n; i++) begin
            tms = ms[i];
            tdi = di[i];
            #6;
            cap_tdo[i] = tdo;
            cap_oe[i] = tdo_oe;
            tck = 1'b1;
            #6;
            tck = 1'b0;
        end
        // Released lines fall back to their pull-up level.
        tms = 1'b1;
        tdi = 1'b1;
    endtask

    // The test reset is asynchronous, so no clock accompanies it.
    task automatic set_trst(input logic v);
        trst_n = v;
    endtask
endmodule
